// ### src/boundary_scan_tap_registers.v
// Behaviour
// - five-bit instruction register, no parity
// - instruction capture loads 00001
// - instruction shift toward tdo, tdi into msb
// - update copies shift stage to active instruction
// - instruction and chain have shift, output stages
// - chain is 281 bits, tdi at 280
// - output cells carry value and enable bit
// - input cells one bit, bit 0 reserved
// - sample captures all pins, bidir by enable
// - extest captures inputs, bidir always as input
// - chain shift toward tdo, tdi into 280
// - update copies chain; extest drives pins
// - chain bit order follows the pin map
// - 32-bit identity register under idcode
// - identity holds revision, model, maker fields
// - identity bit 0 always one
// - single bypass bit, chain left untouched
// - bypass for bypass, float and unknown codes
// - controller reset loads idcode instruction
// - codes 0 extest, 1 sample, 2 id, 3 float
// - sample on tck rise, tdo on fall
// - float instruction releases all driven pins
`timescale 1ns/1ps
`include "tap_consts.vh"

module boundary_scan_tap_registers #(
    parameter [3:0]  ID_VERSION = 4'h1,     // arbitrary value
    parameter [15:0] ID_MODEL   = 16'h4d2c, // arbitrary value
    parameter [10:0] ID_MAKER   = 11'h2a5   // arbitrary value
) (
    input  wire                  clk_sys,
    input  wire                  rst_b,
    input  wire                  tck,
    input  wire                  tms,
    input  wire                  tdi,
    input  wire                  trst_b,
    input  wire [`CHAIN_MSB:0]   pad_di,
    input  wire [`CHAIN_MSB:0]   core_do,
    input  wire [`CHAIN_MSB:0]   core_oe,
    output reg                   tdo,
    output reg                   tdo_oe,
    output reg  [`CHAIN_MSB:0]   pad_do,
    output reg  [`CHAIN_MSB:0]   pad_oe,
    output reg  [`INSTR_WIDTH-1:0] instruction_register
);

    function en_bit;
        input integer i;
        begin
            en_bit = 1'b0;
            if (i >= 220 && i <= 280 && (i % 2) == 0)
                en_bit = 1'b1;
            if (i >= 178 && i <= 206 && (i % 2) == 0)
                en_bit = 1'b1;
            if (i == 175 || i == 172)
                en_bit = 1'b1;
            if (i >= 164 && i <= 170 && (i % 2) == 0)
                en_bit = 1'b1;
            if (i >= 141 && i <= 161 && (i % 2) == 1)
                en_bit = 1'b1;
            if (i >= 130 && i <= 138 && (i % 2) == 0)
                en_bit = 1'b1;
            if (i == 127 || i == 125 || i == 122 || i == 120)
                en_bit = 1'b1;
            if (i >= 110 && i <= 116 && (i % 2) == 0)
                en_bit = 1'b1;
            if (i == 107 || i == 105)
                en_bit = 1'b1;
            if (i >= 92 && i <= 102 && (i % 2) == 0)
                en_bit = 1'b1;
            if (i >= 81 && i <= 89 && (i % 2) == 1)
                en_bit = 1'b1;
            if (i >= 2 && i <= 78 && (i % 2) == 0)
                en_bit = 1'b1;
        end
    endfunction

    function in_bit;
        input integer i;
        begin
            case (i)
                207, 208, 209, 210, 211, 212,
                213, 214, 215, 216, 217, 218,
                176, 173, 162, 139, 128, 123,
                118, 117, 108, 103, 90, 79:
                    in_bit = 1'b1;
                default:
                    in_bit = 1'b0;
            endcase
        end
    endfunction

    function out_bit;
        input integer i;
        begin
            case (i)
                171, 142, 140, 137, 135, 131, 129,
                126, 124, 121, 119, 115, 113, 111,
                109, 106, 104, 101, 99, 97, 95,
                93, 91, 88, 86, 77:
                    out_bit = 1'b1;
                default:
                    out_bit = 1'b0;
            endcase
        end
    endfunction

    // value bit of any driven pin: its enable sits one above
    function val_bit;
        input integer i;
        begin
            val_bit = 1'b0;
            if (i < `CHAIN_MSB)
                val_bit = en_bit(i + 1);
        end
    endfunction

    // which data register sits between tdi and tdo
    function [1:0] data_sel;
        input [`INSTR_WIDTH-1:0] code;
        begin
            case (code)
                `INSTR_EXTEST: data_sel = `SEL_CHAIN;
                `INSTR_SAMPLE: data_sel = `SEL_CHAIN;
                `INSTR_IDCODE: data_sel = `SEL_ID;
                default:       data_sel = `SEL_BYPASS;
            endcase
        end
    endfunction

    wire [`ID_WIDTH-1:0] id_value = {ID_VERSION, ID_MODEL, ID_MAKER, 1'b1};

    reg  [2:0]              tck_sync;
    reg  [1:0]              tms_sync;
    reg  [1:0]              tdi_sync;
    reg  [1:0]              trst_sync;
    reg  [`CHAIN_MSB:0]     pad_meta;
    reg  [`CHAIN_MSB:0]     pad_s;
    reg  [`INSTR_WIDTH-1:0] instr_shift;
    reg  [`CHAIN_MSB:0]     chain_shift;
    reg  [`CHAIN_MSB:0]     chain_update;
    reg  [`ID_WIDTH-1:0]    id_shift;
    reg                     bypass_bit;
    reg  [`CHAIN_MSB:0]     next_capture;
    reg                     next_tdo;
    wire                    tck_rise;
    wire                    tck_fall;
    wire                    tms_s;
    wire                    tdi_s;
    wire                    in_reset;
    wire                    in_cap_i;
    wire                    in_shift_i;
    wire                    in_upd_i;
    wire                    in_cap_d;
    wire                    in_shift_d;
    wire                    in_upd_d;
    wire [1:0]              sel;
    wire                    is_extest;
    wire                    is_sample;
    wire                    is_float;
    integer                 i;
    integer                 j;  // pad loop index, kept apart from i

    // tck through three flops, tms and tdi through two; tms/tdi stay aligned to tck
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tck_sync  <= 3'h0;
            tms_sync  <= 2'h3;   // idle high like the pin's pullup
            tdi_sync  <= 2'h3;
            trst_sync <= 2'h0;
        end else begin
            tck_sync  <= {tck_sync[1:0], tck};
            tms_sync  <= {tms_sync[0], tms};
            tdi_sync  <= {tdi_sync[0], tdi};
            trst_sync <= {trst_sync[0], trst_b};
        end
    end

    // edges from the second and third stage only
    assign tck_rise = tck_sync[1] & ~tck_sync[2];
    assign tck_fall = ~tck_sync[1] & tck_sync[2];
    assign tms_s    = tms_sync[1];
    assign tdi_s    = tdi_sync[1];

    // pin levels are asynchronous to clk_sys
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pad_meta <= {`CHAIN_LEN{1'b0}};
            pad_s    <= {`CHAIN_LEN{1'b0}};
        end else begin
            pad_meta <= pad_di;
            pad_s    <= pad_meta;
        end
    end

    tap_ctrl u_ctrl (
        .clk_sys    (clk_sys),
        .rst_b      (rst_b),
        .tck_rise   (tck_rise),
        .tms        (tms_s),
        .trst_b     (trst_sync[1]),
        .in_reset   (in_reset),
        .in_cap_i   (in_cap_i),
        .in_shift_i (in_shift_i),
        .in_upd_i   (in_upd_i),
        .in_cap_d   (in_cap_d),
        .in_shift_d (in_shift_d),
        .in_upd_d   (in_upd_d)
    );

    // active instruction only ever comes from the output stage
    assign sel       = data_sel(instruction_register);
    assign is_extest = (instruction_register == `INSTR_EXTEST);
    assign is_sample = (instruction_register == `INSTR_SAMPLE);
    assign is_float  = (instruction_register == `INSTR_FLOAT);

    // instruction shift and output stages
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            instr_shift          <= `INSTR_CAPTURE;
            instruction_register <= `INSTR_IDCODE;
        end else if (in_reset) begin
            // idcode held while in reset state
            instruction_register <= `INSTR_IDCODE;
        end else if (tck_rise) begin
            if (in_cap_i) begin
                instr_shift <= `INSTR_CAPTURE;
            end else if (in_shift_i) begin
                instr_shift <= {tdi_s, instr_shift[`INSTR_WIDTH-1:1]};
            end else if (in_upd_i) begin
                instruction_register <= instr_shift;
            end
        end
    end

    // capture image of the chain, per cell type
    always @* begin
        next_capture = chain_shift;
        for (i = 0; i < `CHAIN_LEN; i = i + 1) begin
            if (is_sample) begin
                // every pin, bidir as output when enabled
                if (en_bit(i)) begin
                    next_capture[i] = core_oe[i - 1];
                end else if (out_bit(i)) begin
                    next_capture[i] = core_do[i];
                end else if (val_bit(i) && core_oe[i]) begin
                    next_capture[i] = core_do[i];
                end else if (val_bit(i) || in_bit(i)) begin
                    next_capture[i] = pad_s[i];
                end
            end else if (is_extest) begin
                // inputs only, bidir ignores its enable
                if (in_bit(i) || (val_bit(i) && !out_bit(i))) begin
                    next_capture[i] = pad_s[i];
                end
            end
        end
    end

    // boundary scan chain shift and output stages
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            chain_shift  <= {`CHAIN_LEN{1'b0}};
            chain_update <= {`CHAIN_LEN{1'b0}};
        end else if (tck_rise && sel == `SEL_CHAIN) begin
            if (in_cap_d) begin
                chain_shift <= next_capture;
            end else if (in_shift_d) begin
                chain_shift <= {tdi_s, chain_shift[`CHAIN_MSB:1]};
            end else if (in_upd_d) begin
                chain_update <= chain_shift;
            end
        end
    end

    // identity register and bypass bit
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            id_shift   <= {`ID_WIDTH{1'b0}};
            bypass_bit <= 1'b0;
        end else if (tck_rise) begin
            if (sel == `SEL_ID) begin
                if (in_cap_d) begin
                    id_shift <= id_value;
                end else if (in_shift_d) begin
                    id_shift <= {tdi_s, id_shift[`ID_WIDTH-1:1]};
                end
            end
            if (sel == `SEL_BYPASS) begin
                if (in_cap_d) begin
                    bypass_bit <= 1'b0;
                end else if (in_shift_d) begin
                    bypass_bit <= tdi_s;
                end
            end
        end
    end

    // serial output source, picked by state and selection
    always @* begin
        next_tdo = tdo;
        if (in_shift_i) begin
            next_tdo = instr_shift[0];
        end else if (in_shift_d) begin
            case (sel)
                `SEL_CHAIN: next_tdo = chain_shift[0];
                `SEL_ID:    next_tdo = id_shift[0];
                default:    next_tdo = bypass_bit;
            endcase
        end
    end

    // tdo changes on tck fall only, driven in shift states
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo    <= next_tdo;
            tdo_oe <= in_shift_i | in_shift_d;
        end
    end

    // pin muxing; registered so pads see no decode glitches
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pad_do <= {`CHAIN_LEN{1'b0}};
            pad_oe <= {`CHAIN_LEN{1'b0}};
        end else begin
            for (j = 0; j < `CHAIN_LEN; j = j + 1) begin
                if (!val_bit(j)) begin
                    pad_do[j] <= 1'b0;  // inputs, enables, reserved
                    pad_oe[j] <= 1'b0;
                end else if (is_extest) begin
                    // value and enable from the output stage
                    pad_do[j] <= chain_update[j];
                    pad_oe[j] <= chain_update[j + 1];
                end else if (is_float) begin
                    pad_do[j] <= core_do[j];
                    pad_oe[j] <= 1'b0;
                end else begin
                    pad_do[j] <= core_do[j];
                    pad_oe[j] <= core_oe[j];
                end
            end
        end
    end

endmodule

// ### src/tap_consts.vh
`ifndef TAP_CONSTS_VH
`define TAP_CONSTS_VH

// register widths
`define INSTR_WIDTH      5
`define CHAIN_LEN        281
`define CHAIN_MSB        280
`define ID_WIDTH         32

// instruction codes, anything else falls back to bypass
`define INSTR_EXTEST     5'h00
`define INSTR_SAMPLE     5'h01
`define INSTR_IDCODE     5'h02
`define INSTR_FLOAT      5'h03
`define INSTR_BYPASS     5'h1f

// pattern parallel-loaded into the instruction shift stage
`define INSTR_CAPTURE    5'h01

// identification field positions
`define ID_VER_MSB       31
`define ID_VER_LSB       28
`define ID_MODEL_MSB     27
`define ID_MODEL_LSB     12
`define ID_MAKER_MSB     11
`define ID_MAKER_LSB     1
`define ID_MARK_BIT      0

// data register selection codes
`define SEL_CHAIN        2'h0
`define SEL_ID           2'h1
`define SEL_BYPASS       2'h2

`endif

// ### src/tap_ctrl.v
`timescale 1ns/1ps

// standard 16-state test controller, advanced on detected tck rises
module tap_ctrl (
    input  wire clk_sys,
    input  wire rst_b,
    input  wire tck_rise,
    input  wire tms,
    input  wire trst_b,
    output wire in_reset,
    output wire in_cap_i,
    output wire in_shift_i,
    output wire in_upd_i,
    output wire in_cap_d,
    output wire in_shift_d,
    output wire in_upd_d
);

    localparam [15:0] S_TLR  = 16'h0001;
    localparam [15:0] S_RTI  = 16'h0002;
    localparam [15:0] S_SDS  = 16'h0004;
    localparam [15:0] S_CDR  = 16'h0008;
    localparam [15:0] S_SHDR = 16'h0010;
    localparam [15:0] S_E1DR = 16'h0020;
    localparam [15:0] S_PDR  = 16'h0040;
    localparam [15:0] S_E2DR = 16'h0080;
    localparam [15:0] S_UDR  = 16'h0100;
    localparam [15:0] S_SIS  = 16'h0200;
    localparam [15:0] S_CIR  = 16'h0400;
    localparam [15:0] S_SHIR = 16'h0800;
    localparam [15:0] S_E1IR = 16'h1000;
    localparam [15:0] S_PIR  = 16'h2000;
    localparam [15:0] S_E2IR = 16'h4000;
    localparam [15:0] S_UIR  = 16'h8000;

    reg [15:0] state;
    reg [15:0] next_state;

    // next state from the sampled mode select
    always @* begin
        case (state)
            S_TLR:   next_state = tms ? S_TLR  : S_RTI;
            S_RTI:   next_state = tms ? S_SDS  : S_RTI;
            S_SDS:   next_state = tms ? S_SIS  : S_CDR;
            S_CDR:   next_state = tms ? S_E1DR : S_SHDR;
            S_SHDR:  next_state = tms ? S_E1DR : S_SHDR;
            S_E1DR:  next_state = tms ? S_UDR  : S_PDR;
            S_PDR:   next_state = tms ? S_E2DR : S_PDR;
            S_E2DR:  next_state = tms ? S_UDR  : S_SHDR;
            S_UDR:   next_state = tms ? S_SDS  : S_RTI;
            S_SIS:   next_state = tms ? S_TLR  : S_CIR;
            S_CIR:   next_state = tms ? S_E1IR : S_SHIR;
            S_SHIR:  next_state = tms ? S_E1IR : S_SHIR;
            S_E1IR:  next_state = tms ? S_UIR  : S_PIR;
            S_PIR:   next_state = tms ? S_E2IR : S_PIR;
            S_E2IR:  next_state = tms ? S_UIR  : S_SHIR;
            S_UIR:   next_state = tms ? S_SDS  : S_RTI;
            default: next_state = S_TLR;
        endcase
    end

    // test reset pin forces the reset state without waiting for tck
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state <= S_TLR;
        end else if (!trst_b) begin
            state <= S_TLR;
        end else if (tck_rise) begin
            state <= next_state;
        end
    end

    assign in_reset   = (state == S_TLR);
    assign in_cap_i   = (state == S_CIR);
    assign in_shift_i = (state == S_SHIR);
    assign in_upd_i   = (state == S_UIR);
    assign in_cap_d   = (state == S_CDR);
    assign in_shift_d = (state == S_SHDR);
    assign in_upd_d   = (state == S_UDR);

endmodule

// ### verif/tap_regs_props.sv
`timescale 1ns/1ps
`include "tap_consts.vh"

module tap_regs_props (
    input wire                    clk_sys,
    input wire                    rst_b,
    input wire                    tck,
    input wire                    tms,
    input wire                    tdi,
    input wire                    trst_b,
    input wire [`CHAIN_MSB:0]     pad_di,
    input wire [`CHAIN_MSB:0]     core_do,
    input wire [`CHAIN_MSB:0]     core_oe,
    input wire                    tdo,
    input wire                    tdo_oe,
    input wire [`CHAIN_MSB:0]     pad_do,
    input wire [`CHAIN_MSB:0]     pad_oe,
    input wire [`INSTR_WIDTH-1:0] instruction_register
);
    // one clock domain, so one default clock and reset
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    a_reserved_cell_idle: assert property (
        pad_oe[0] == 1'b0 && pad_do[0] == 1'b0)
        else $error("reserved cell drives a pin");

    a_input_never_driven: assert property (
        pad_oe[139] == 1'b0 && pad_oe[212] == 1'b0 && pad_oe[280] == 1'b0)
        else $error("pin enable set at an input or enable position");

    a_float_release: assert property (
        (instruction_register == `INSTR_FLOAT
         && $stable(instruction_register)) |-> pad_oe == '0)
        else $error("pin driven while float instruction active");

    // functional pin path, one clock late
    a_func_follow: assert property (
        (instruction_register != `INSTR_EXTEST
         && $stable(instruction_register) && $past(rst_b))
        |-> pad_do[279] == $past(core_do[279])
            && (instruction_register == `INSTR_FLOAT
                || pad_oe[279] == $past(core_oe[279])))
        else $error("pin does not follow functional value");

    // serial out moves after tck fall only
    a_tdo_after_fall: assert property (
        $changed(tdo) |-> !$past(tck, 2))
        else $error("serial out changed outside a tck low phase");

    // output enable moves after tck fall
    a_tdo_oe_fall: assert property (
        $changed(tdo_oe) |-> !$past(tck, 2))
        else $error("serial out enable changed outside a tck low phase");

    a_trst_idcode: assert property (
        !trst_b [*6] |=> instruction_register == `INSTR_IDCODE)
        else $error("test reset did not select identity");

    a_instr_on_rise: assert property (
        ($changed(instruction_register) && trst_b && $past(trst_b, 6))
        |-> $past(tck, 2))
        else $error("instruction changed away from a tck rise");

    c_float_seen: cover property (instruction_register == `INSTR_FLOAT);
    c_extest_drive: cover property (
        instruction_register == `INSTR_EXTEST && pad_oe[279]);
    c_shift_one: cover property (tdo_oe && tdo);
endmodule

bind boundary_scan_tap_registers tap_regs_props i_props (
    .clk_sys(clk_sys), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi),
    .trst_b(trst_b), .pad_di(pad_di), .core_do(core_do),
    .core_oe(core_oe), .tdo(tdo), .tdo_oe(tdo_oe), .pad_do(pad_do),
    .pad_oe(pad_oe), .instruction_register(instruction_register)
);

// ### verif/jtag_tester.sv
`timescale 1ns/1ps

// outside tester: tck stands low between frames, tdi rests high (pull-up)
module jtag_tester (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    localparam int HALF = 40;

    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // change on fall, device samples rise; tdo read late in high phase
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #HALF tck = 1'b1;
        #HALF q = tdo;
        tck = 1'b0;
    endtask

    task automatic go(input logic m);
        logic q;
        step(m, 1'b1, q);
    endtask

    // five highs reach test-logic-reset from any state, then idle
    task automatic reset_tap();
        repeat (5) go(1'b1);
        go(1'b0);
        #(2 * HALF);
    endtask

    // whole scan lsb first, then update and back to idle
    task automatic scan(input logic is_instr, input int n,
                        input logic [280:0] din, output logic [280:0] dout);
        logic q;
        dout = '0;
        go(1'b1);
        if (is_instr) go(1'b1);
        go(1'b0);
        go(1'b0);
        for (int k = 0; k < n; k++) begin
            step(k == n - 1, din[k], q);
            dout[k] = q;
        end
        go(1'b1);
        go(1'b0);
        #(2 * HALF);
    endtask
endmodule

// ### verif/boundary_scan_tap_registers_tb.sv
`timescale 1ns/1ps
`include "tap_consts.vh"

module boundary_scan_tap_registers_tb;
    localparam logic [3:0]  VER   = 4'h6;     // arbitrary value
    localparam logic [15:0] MODEL = 16'h3b71; // arbitrary value
    localparam logic [10:0] MAKER = 11'h155;  // arbitrary value

    logic         clk_sys;
    logic         rst_b;
    logic         trst_b;
    logic [280:0] pad_di;
    logic [280:0] core_do;
    logic [280:0] core_oe;
    logic [280:0] pad_do;
    logic [280:0] pad_oe;
    logic [280:0] got;
    logic         tck;
    logic         tms;
    logic         tdi;
    logic         tdo;
    logic         tdo_oe;
    logic [4:0]   instruction_register;
    wire          tdo_line;
    wire [3:0]    pin_view;
    int           fail_count = 0;
    int           samples_checked = 0;

    // a released serial out shows the inverse, never a lucky level
    assign tdo_line = tdo_oe ? tdo : ~tdo;

    // value and enable of the two watched pins, value bits 279 and 277
    assign pin_view = {pad_do[279], pad_oe[279], pad_do[277], pad_oe[277]};

    boundary_scan_tap_registers #(
        .ID_VERSION(VER), .ID_MODEL(MODEL), .ID_MAKER(MAKER)
    ) i_dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .tck(tck), .tms(tms),
        .tdi(tdi), .trst_b(trst_b), .pad_di(pad_di), .core_do(core_do),
        .core_oe(core_oe), .tdo(tdo), .tdo_oe(tdo_oe), .pad_do(pad_do),
        .pad_oe(pad_oe), .instruction_register(instruction_register)
    );

    jtag_tester i_tester (
        .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_line)
    );

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // chain image view: bits 280..277, 212, 139
    function automatic logic [31:0] cap_of(input logic [280:0] v);
        return 32'({v[280:277], v[212], v[139]});
    endfunction

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic load_ir(input logic [4:0] code);
        i_tester.scan(1'b1, 5, 281'(code), got);
        check("instr capture", 32'(got[4:0]), 32'(`INSTR_CAPTURE));
        check("instr update", 32'(instruction_register), 32'(code));
    endtask

    task automatic t_idcode();
        check("reset instr", 32'(instruction_register), 32'(`INSTR_IDCODE));
        i_tester.scan(1'b0, 32, '0, got);
        check("identity", got[31:0], {VER, MODEL, MAKER, 1'b1});
    endtask

    // float, undefined and bypass codes all give a one-bit path
    task automatic t_bypass();
        logic [4:0] codes [5] = '{5'h03, 5'h04, 5'h0f, 5'h1e, 5'h1f};
        for (int c = 0; c < 5; c++) begin
            load_ir(codes[c]);
            if (codes[c] == `INSTR_FLOAT)
                check("float oe", 32'(|pad_oe), 32'h0);
            i_tester.scan(1'b0, 9, 281'h1a5, got);
            check("bypass path", 32'(got[8:0]), 32'h14a);
        end
    endtask

    // preload under sample, then drive, capture and keep under extest
    task automatic t_chain();
        load_ir(`INSTR_SAMPLE);
        i_tester.scan(1'b0, 281, {4'b1101, 277'h0}, got);
        check("sample capture", cap_of(got), 32'h26);
        check("sample pins", 32'(pin_view), 32'h4);
        load_ir(`INSTR_EXTEST);
        check("preload drive", 32'(pin_view), 32'he);
        i_tester.scan(1'b0, 281, {4'b1011, 277'h0}, got);
        check("extest capture", cap_of(got), 32'h36);
        check("extest drive", 32'(pin_view), 32'h7);
        load_ir(`INSTR_BYPASS);
        check("bypass pins", 32'({pad_do[279], pad_oe[279]}), 32'h1);
        i_tester.scan(1'b0, 281, '1, got);
        load_ir(`INSTR_EXTEST);
        check("chain kept", 32'(pin_view), 32'h7);
    endtask

    task automatic t_reset();
        i_tester.reset_tap();
        check("tms reset", 32'(instruction_register), 32'(`INSTR_IDCODE));
        load_ir(`INSTR_BYPASS);
        @(negedge clk_sys);
        trst_b = 1'b0;
        repeat (8) @(negedge clk_sys);
        trst_b = 1'b1;
        repeat (4) @(negedge clk_sys);
        check("test reset", 32'(instruction_register), 32'(`INSTR_IDCODE));
        i_tester.go(1'b0);
    endtask

    // main sequence; pins: 139 low, 279 enabled, 277 disabled
    initial begin
        rst_b = 1'b0;
        trst_b = 1'b1;
        pad_di = {{141{1'b1}}, 1'b0, {139{1'b1}}};
        core_do = '0;
        core_oe = {1'b0, 1'b1, 279'h0};
        repeat (10) @(negedge clk_sys);
        rst_b = 1'b1;
        repeat (5) @(negedge clk_sys);
        i_tester.reset_tap();
        t_idcode();
        t_bypass();
        t_chain();
        t_reset();
        final_report();
    end

    // hang guard, about 100k system clocks
    initial begin
        #1000000;
        fail_count++;
        final_report();
    end
endmodule
